//--- rtl/mcpc_port_config.sv
// How it works
// - mixed mode pairs optical with coaxial line
// - same mode pairs optical-optical, coaxial-coaxial
// - first priority prefers optical, or line 1
// - second priority prefers coaxial, or line 2
// - split copies inputs to same-type outputs
// - input converter clock: stream or word clock
// - report 48k/44.1k family, cleared without input
// - rate single/double/quad: 64/32/16 channels
// - report frame and channel format, cleared
// - output timing: host, stream or word clock, default host
// - output frame follow/96k/48k, default follow
// - output channels follow/64/56, default follow
// - switch off: dip settings, host control writes refused
`timescale 1ns/1ps
`default_nettype none
`include "mcpc_consts.svh"

module mcpc_port_config (
   input  wire logic                      clk_i,
   input  wire logic                      reset_n_i,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [3:0]                wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic      [31:0]               wb_dat_o,
   output logic                           wb_ack_o,
   output logic                           irq_o,
   input  wire logic [`MCPC_NUM_LINES-1:0] line_clk_i,
   input  wire logic [`MCPC_NUM_LINES-1:0] line_lock_i,
   input  wire logic [`MCPC_NUM_LINES-1:0] line_fs48_i,
   input  wire logic [`MCPC_NUM_LINES-1:0] line_frame96_i,
   input  wire logic [`MCPC_NUM_LINES-1:0] line_ch56_i,
   input  wire logic                      wclk_i,
   input  wire logic                      host_ctrl_sw_i,
   input  wire logic [`MCPC_CTRL_W-1:0]   dip_cfg_i,
   output logic      [1:0]                pair_a_line_o,
   output logic      [1:0]                pair_b_line_o,
   output logic                           rx_valid_o,
   output logic                           rx_fs48_o,
   output logic                           rx_frame96_o,
   output logic                           rx_ch56_o,
   output logic                           split_en_o,
   output logic                           in_src_en_o,
   output logic                           in_src_clk_wclk_o,
   output logic      [1:0]                rate_o,
   output logic      [6:0]                max_channels_o,
   output logic      [1:0]                out_timing_o,
   output logic                           out_frame96_o,
   output logic                           out_ch56_o
);

   typedef struct packed {
      mcpc_pkg::mcpc_ctrl_t       ctrl;
      logic                       ack;
      logic [31:0]                rdata;
      logic [`MCPC_IRQ_W-1:0]     irq_stat;
      logic [`MCPC_IRQ_W-1:0]     irq_mask;
      logic [1:0]                 sel_a;
      logic [1:0]                 sel_b;
      logic                       rx_valid;
      logic                       fs48;
      logic                       frame96;
      logic                       ch56;
      logic [6:0]                 max_ch;
      logic [1:0]                 out_timing;
      logic                       out_frame96;
      logic                       out_ch56;
      mcpc_pkg::mcpc_ctrl_t       eff;
      logic [`MCPC_CTRL_W-1:0]    dip_prev;
      mcpc_pkg::mcpc_ctrl_t       dip_ok;
   } mcpc_main_st_t;

   mcpc_main_st_t st_q;
   mcpc_main_st_t st_d;

   // pin synchronisers
   logic [`MCPC_NUM_SYNC-1:0] raw_pins;
   logic [`MCPC_NUM_SYNC-1:0] sync_pins;

   assign raw_pins = {dip_cfg_i, host_ctrl_sw_i, wclk_i, line_ch56_i, line_frame96_i,
                      line_fs48_i, line_lock_i, line_clk_i};

   genvar gi;
   generate
      for (gi = 0; gi < `MCPC_NUM_SYNC; gi = gi + 1) begin : g_sync
         mcpc_sync u_sync (
            .clk_i     (clk_i),
            .reset_n_i (reset_n_i),
            .async_i   (raw_pins[gi]),
            .sync_o    (sync_pins[gi])
         );
      end
   endgenerate

   logic [`MCPC_NUM_LINES-1:0] clk_s;
   logic [`MCPC_NUM_LINES-1:0] lock_s;
   logic [`MCPC_NUM_LINES-1:0] fs48_s;
   logic [`MCPC_NUM_LINES-1:0] frame96_s;
   logic [`MCPC_NUM_LINES-1:0] ch56_s;
   logic                       wclk_s;
   logic                       host_ctrl_s;
   logic [`MCPC_CTRL_W-1:0]    dip_s;

   assign clk_s       = sync_pins[3:0];
   assign lock_s      = sync_pins[7:4];
   assign fs48_s      = sync_pins[11:8];
   assign frame96_s   = sync_pins[15:12];
   assign ch56_s      = sync_pins[19:16];
   assign wclk_s      = sync_pins[20];
   assign host_ctrl_s = sync_pins[21];
   assign dip_s       = sync_pins[34:22];

   // clock activity per line plus word clock
   logic [`MCPC_NUM_LINES:0] act;
   logic [`MCPC_NUM_LINES:0] act_lvl;

   // word clock rides as the top entry
   assign act_lvl = {wclk_s, clk_s};

   generate
      for (gi = 0; gi <= `MCPC_NUM_LINES; gi = gi + 1) begin : g_act
         mcpc_activity u_act (
            .clk_i     (clk_i),
            .reset_n_i (reset_n_i),
            .level_i   (act_lvl[gi]),
            .active_o  (act[gi])
         );
      end
   endgenerate

   logic [`MCPC_NUM_LINES-1:0] line_valid;
   logic                       wclk_valid;

   assign line_valid = lock_s & act[`MCPC_NUM_LINES-1:0];
   assign wclk_valid = act[`MCPC_NUM_LINES];

   // bus decode
   logic req;
   logic wr_commit;
   logic rd_commit;
   logic host_locked;

   assign req         = wb_cyc_i & wb_stb_i;
   assign wr_commit   = st_q.ack & req & wb_we_i;
   assign rd_commit   = st_q.ack & req & ~wb_we_i;
   assign host_locked = ~host_ctrl_s;

   // next-state variables
   mcpc_pkg::mcpc_ctrl_t eff;
   logic [1:0]           prim_a;
   logic [1:0]           part_a;
   logic [1:0]           prim_b;
   logic [1:0]           part_b;
   logic [1:0]           src;
   logic                 any_valid;
   logic [`MCPC_IRQ_W-1:0] irq_set;
   logic [`MCPC_IRQ_W-1:0] irq_clr;
   logic [31:0]          stat_word;
   logic                 in_ref_valid;

   always_comb begin
      st_d      = st_q;
      irq_set   = '0;
      irq_clr   = '0;

      // switch bank taken only once two samples agree
      st_d.dip_prev = dip_s;
      if (dip_s == st_q.dip_prev) begin
         st_d.dip_ok = mcpc_pkg::mcpc_ctrl_t'(dip_s);
      end

      eff = host_locked ? st_q.dip_ok : st_q.ctrl;

      // redundant pairs and preferred line of each
      if (eff.mode == mcpc_pkg::mixed_media) begin
         if (eff.prio == mcpc_pkg::first_line_preferred) begin
            prim_a = `MCPC_LINE_OPT1;
            part_a = `MCPC_LINE_COAX1;
            prim_b = `MCPC_LINE_OPT2;
            part_b = `MCPC_LINE_COAX2;
         end else begin
            prim_a = `MCPC_LINE_COAX1;
            part_a = `MCPC_LINE_OPT1;
            prim_b = `MCPC_LINE_COAX2;
            part_b = `MCPC_LINE_OPT2;
         end
      end else begin
         if (eff.prio == mcpc_pkg::first_line_preferred) begin
            prim_a = `MCPC_LINE_OPT1;
            part_a = `MCPC_LINE_OPT2;
            prim_b = `MCPC_LINE_COAX1;
            part_b = `MCPC_LINE_COAX2;
         end else begin
            prim_a = `MCPC_LINE_OPT2;
            part_a = `MCPC_LINE_OPT1;
            prim_b = `MCPC_LINE_COAX2;
            part_b = `MCPC_LINE_COAX1;
         end
      end

      // failover: partner only while it is valid and the preferred one is not
      st_d.sel_a = (!line_valid[prim_a] && line_valid[part_a]) ? part_a : prim_a;
      st_d.sel_b = (!line_valid[prim_b] && line_valid[part_b]) ? part_b : prim_b;

      any_valid     = line_valid[st_d.sel_a] | line_valid[st_d.sel_b];
      src           = line_valid[st_d.sel_a] ? st_d.sel_a : st_d.sel_b;
      st_d.rx_valid = any_valid;
      st_d.fs48     = any_valid & fs48_s[src];
      st_d.frame96  = any_valid & frame96_s[src];
      st_d.ch56     = any_valid & ch56_s[src];

      unique case (eff.rate)
         mcpc_pkg::single_rate: st_d.max_ch = `MCPC_MAXCH_SINGLE;
         mcpc_pkg::double_rate: st_d.max_ch = `MCPC_MAXCH_DOUBLE;
         mcpc_pkg::quad_rate:   st_d.max_ch = `MCPC_MAXCH_QUAD;
         default:               st_d.max_ch = `MCPC_MAXCH_SINGLE;
      endcase

      if (!eff.out_src_en) begin
         st_d.out_timing = `MCPC_OCLK_HOST;
      end else if (eff.out_src_clk) begin
         st_d.out_timing = `MCPC_OCLK_WCLK;
      end else begin
         st_d.out_timing = `MCPC_OCLK_STREAM;
      end

      unique case (eff.out_frame)
         mcpc_pkg::frame_96k: st_d.out_frame96 = 1'b1;
         mcpc_pkg::frame_48k: st_d.out_frame96 = 1'b0;
         default:             st_d.out_frame96 = st_d.frame96;
      endcase

      unique case (eff.out_ch)
         `MCPC_CH_64: st_d.out_ch56 = 1'b0;
         `MCPC_CH_56: st_d.out_ch56 = 1'b1;
         default:     st_d.out_ch56 = st_d.ch56;
      endcase

      st_d.eff = eff;

      // events
      if (st_d.rx_valid != st_q.rx_valid) begin
         irq_set[`MCPC_IRQ_VALID] = 1'b1;
      end
      if ((st_d.sel_a != st_q.sel_a) || (st_d.sel_b != st_q.sel_b)) begin
         irq_set[`MCPC_IRQ_FAILOVER] = 1'b1;
      end
      if (st_d.rx_valid && st_q.rx_valid && (st_d.fs48 != st_q.fs48)) begin
         irq_set[`MCPC_IRQ_FS] = 1'b1;
      end

      // register writes at the acknowledging edge
      if (wr_commit && (wb_adr_i == `MCPC_ADDR_CTRL)) begin
         if (host_locked) begin
            irq_set[`MCPC_IRQ_REFUSED] = 1'b1;
         end else begin
            if (wb_sel_i[0]) begin
               st_d.ctrl[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               st_d.ctrl[12:8] = wb_dat_i[12:8];
            end
         end
      end
      if (wr_commit && (wb_adr_i == `MCPC_ADDR_IRQ_MASK) && wb_sel_i[0]) begin
         st_d.irq_mask = wb_dat_i[`MCPC_IRQ_W-1:0];
      end
      if (rd_commit && (wb_adr_i == `MCPC_ADDR_IRQ_STAT)) begin
         // clear only what this read returned
         irq_clr = st_q.rdata[`MCPC_IRQ_W-1:0];
      end

      // set wins over read-clear
      st_d.irq_stat = (st_q.irq_stat & ~irq_clr) | irq_set;

      // input converter reference present
      in_ref_valid = st_q.eff.in_src_clk ? wclk_valid : st_q.rx_valid;

      stat_word = {17'h0_0000,
                   in_ref_valid,
                   host_locked,
                   wclk_valid,
                   line_valid,
                   st_q.sel_b,
                   st_q.sel_a,
                   st_q.ch56,
                   st_q.frame96,
                   st_q.fs48,
                   st_q.rx_valid};

      // single-cycle answer, dropped the cycle after
      st_d.ack = req & ~st_q.ack;
      if (req && !st_q.ack) begin
         unique case (wb_adr_i)
            `MCPC_ADDR_CTRL:     st_d.rdata = {19'h0_0000, st_q.eff};
            `MCPC_ADDR_STAT:     st_d.rdata = stat_word;
            `MCPC_ADDR_IRQ_STAT: st_d.rdata = {28'h000_0000, st_q.irq_stat};
            `MCPC_ADDR_IRQ_MASK: st_d.rdata = {28'h000_0000, st_q.irq_mask};
            default:             st_d.rdata = 32'h0000_0000;
         endcase
      end else begin
         // data leaves the bus with ack
         st_d.rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         st_q          <= '0;
         st_q.ctrl     <= `MCPC_CTRL_RST;
         st_q.eff      <= `MCPC_CTRL_RST;
         st_q.irq_stat <= `MCPC_IRQ_RST;
         st_q.irq_mask <= `MCPC_IRQ_RST;
         st_q.max_ch   <= `MCPC_MAXCH_SINGLE;
         st_q.dip_ok   <= `MCPC_CTRL_RST;
         // preferred lines of the reset pairing, so no false switch event
         st_q.sel_a    <= `MCPC_LINE_OPT1;
         st_q.sel_b    <= `MCPC_LINE_OPT2;
      end else begin
         st_q <= st_d;
      end
   end

   assign wb_dat_o          = st_q.rdata;
   assign wb_ack_o          = st_q.ack;
   assign irq_o             = |(st_q.irq_stat & st_q.irq_mask);
   assign pair_a_line_o     = st_q.sel_a;
   assign pair_b_line_o     = st_q.sel_b;
   assign rx_valid_o        = st_q.rx_valid;
   assign rx_fs48_o         = st_q.fs48;
   assign rx_frame96_o      = st_q.frame96;
   assign rx_ch56_o         = st_q.ch56;
   assign split_en_o        = st_q.eff.split;
   assign in_src_en_o       = st_q.eff.in_src_en;
   assign in_src_clk_wclk_o = st_q.eff.in_src_en & st_q.eff.in_src_clk;
   assign rate_o            = st_q.eff.rate;
   assign max_channels_o    = st_q.max_ch;
   assign out_timing_o      = st_q.out_timing;
   assign out_frame96_o     = st_q.out_frame96;
   assign out_ch56_o        = st_q.out_ch56;

endmodule : mcpc_port_config

`default_nettype wire

//--- rtl/mcpc_consts.svh
`ifndef MCPC_CONSTS_SVH
`define MCPC_CONSTS_SVH

// clock and timing
`define MCPC_CLK_MHZ          100
`define MCPC_ACT_TIMEOUT_NS   2000
`define MCPC_ACT_TIMEOUT_CYC  ((`MCPC_ACT_TIMEOUT_NS * `MCPC_CLK_MHZ + 999) / 1000)
`define MCPC_ACT_CNT_W        8

// register byte addresses
`define MCPC_ADDR_CTRL        4'h0
`define MCPC_ADDR_STAT        4'h4
`define MCPC_ADDR_IRQ_STAT    4'h8
`define MCPC_ADDR_IRQ_MASK    4'hC

// widths and reset values
`define MCPC_CTRL_W           13
`define MCPC_CTRL_RST         13'h0000
`define MCPC_IRQ_W            4
`define MCPC_IRQ_RST          4'h0
`define MCPC_NUM_LINES        4
`define MCPC_NUM_SYNC         35

// irq bit positions
`define MCPC_IRQ_VALID        0
`define MCPC_IRQ_FAILOVER     1
`define MCPC_IRQ_FS           2
`define MCPC_IRQ_REFUSED      3

// line indices: optical 1, optical 2, coaxial 1, coaxial 2
`define MCPC_LINE_OPT1        2'h0
`define MCPC_LINE_OPT2        2'h1
`define MCPC_LINE_COAX1       2'h2
`define MCPC_LINE_COAX2       2'h3

// channel format select codes
`define MCPC_CH_FOLLOW        2'h0
`define MCPC_CH_64            2'h1
`define MCPC_CH_56            2'h2

// max channel counts per rate
`define MCPC_MAXCH_SINGLE     7'h40
`define MCPC_MAXCH_DOUBLE     7'h20
`define MCPC_MAXCH_QUAD       7'h10

// output timing source codes
`define MCPC_OCLK_HOST        2'h0
`define MCPC_OCLK_STREAM      2'h1
`define MCPC_OCLK_WCLK        2'h2

`endif

//--- rtl/mcpc_pkg.sv
package mcpc_pkg;

   typedef enum logic { mixed_media = 1'b0, same_media = 1'b1 } mcpc_mode_t;

   typedef enum logic { first_line_preferred = 1'b0, second_line_preferred = 1'b1 } mcpc_prio_t;

   typedef enum logic [1:0] {
      single_rate = 2'h0, double_rate = 2'h1, quad_rate = 2'h2, rate_rsvd = 2'h3
   } mcpc_rate_t;

   typedef enum logic [1:0] {
      follow_received_format = 2'h0, frame_96k = 2'h1, frame_48k = 2'h2, frame_rsvd = 2'h3
   } mcpc_frame_sel_t;

   typedef struct packed {
      logic [1:0]      out_ch;
      mcpc_frame_sel_t out_frame;
      logic            out_src_clk;
      logic            out_src_en;
      mcpc_rate_t      rate;
      logic            in_src_clk;
      logic            in_src_en;
      logic            split;
      mcpc_prio_t      prio;
      mcpc_mode_t      mode;
   } mcpc_ctrl_t;

   typedef struct packed {
      logic s1;
      logic s2;
   } mcpc_sync_st_t;

   typedef struct packed {
      logic       prev;
      logic [7:0] cnt;
      logic       active;
   } mcpc_act_st_t;

endpackage : mcpc_pkg

//--- rtl/mcpc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module mcpc_sync (
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   input  wire logic async_i,
   output logic      sync_o
);

   mcpc_pkg::mcpc_sync_st_t st_q;
   mcpc_pkg::mcpc_sync_st_t st_d;

   always_comb begin
      st_d    = st_q;
      st_d.s1 = async_i;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_o = st_q.s2;

endmodule : mcpc_sync

`default_nettype wire

//--- rtl/mcpc_activity.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcpc_consts.svh"

module mcpc_activity (
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   input  wire logic level_i,
   output logic      active_o
);

   localparam logic [`MCPC_ACT_CNT_W-1:0] TIMEOUT_LAST = `MCPC_ACT_CNT_W'(`MCPC_ACT_TIMEOUT_CYC - 1);

   mcpc_pkg::mcpc_act_st_t st_q;
   mcpc_pkg::mcpc_act_st_t st_d;

   // clock counts as running while rising edges come faster than the timeout
   always_comb begin
      st_d      = st_q;
      st_d.prev = level_i;
      if (level_i && !st_q.prev) begin
         st_d.cnt    = '0;
         st_d.active = 1'b1;
      end else if (st_q.cnt == TIMEOUT_LAST) begin
         st_d.active = 1'b0;
      end else begin
         st_d.cnt = st_q.cnt + 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign active_o = st_q.active;

endmodule : mcpc_activity

`default_nettype wire

//--- dv/mcpc_line_model.sv
`timescale 1ns/1ps
`default_nettype none

module mcpc_line_model #(
   parameter logic [3:0] FS = 4'h0,
   parameter logic [3:0] FR = 4'h0,
   parameter logic [3:0] CH = 4'h0
) (
   input  wire logic [3:0] en_i,
   output logic      [3:0] clk_o,
   output logic      [3:0] lock_o,
   output logic      [3:0] fs48_o,
   output logic      [3:0] frame96_o,
   output logic      [3:0] ch56_o,
   output logic            wclk_o
);
   // line clocks toggle only on live lines, off-phase to the system clock
   initial begin
      clk_o = 4'h0;
      wclk_o = 1'b0;
      #3.3;
      forever begin
         #80;
         clk_o = clk_o ^ en_i;
         wclk_o = ~wclk_o;
      end
   end
   assign lock_o = en_i;
   // dead lines show inverted format bits, never the last good ones
   assign fs48_o = FS ^ ~en_i;
   assign frame96_o = FR ^ ~en_i;
   assign ch56_o = CH ^ ~en_i;
endmodule : mcpc_line_model
`default_nettype wire

//--- dv/mcpc_port_config_sva.sv
`timescale 1ns/1ps
`default_nettype none

module mcpc_port_config_sva (
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic [3:0]  line_lock_i,
   input wire logic [1:0]  pair_a_line_o,
   input wire logic [1:0]  pair_b_line_o,
   input wire logic        rx_valid_o,
   input wire logic        rx_fs48_o,
   input wire logic        rx_frame96_o,
   input wire logic        rx_ch56_o,
   input wire logic        in_src_en_o,
   input wire logic        in_src_clk_wclk_o,
   input wire logic [1:0]  rate_o,
   input wire logic [6:0]  max_channels_o,
   input wire logic [1:0]  out_timing_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_unlocked;
      (line_lock_i == 4'h0) [*6];
   endsequence
   chk_ack_resp: assert property (s_req |=> wb_ack_o) else $error("no ack after request");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   chk_idle_dat: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data without ack");
   chk_rx_clear: assert property (
      !rx_valid_o |-> !rx_fs48_o && !rx_frame96_o && !rx_ch56_o) else $error("format shown without input");
   chk_no_lock: assert property (s_unlocked |-> !rx_valid_o) else $error("valid without lock");
   chk_in_clk: assert property (!in_src_en_o |-> !in_src_clk_wclk_o) else $error("converter clock while off");
   chk_rate_max: assert property (
      $stable(rate_o) && rate_o != 2'h3 |-> max_channels_o == (7'h40 >> rate_o)) else $error("channel limit");
   chk_pair_lines: assert property (
      pair_a_line_o != 2'h3 && pair_b_line_o != 2'h0) else $error("line outside its pair");
   chk_out_code: assert property (out_timing_o != 2'h3) else $error("bad output timing code");
endmodule : mcpc_port_config_sva

bind mcpc_port_config mcpc_port_config_sva u_sva (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .line_lock_i(line_lock_i),
   .pair_a_line_o(pair_a_line_o), .pair_b_line_o(pair_b_line_o), .rx_valid_o(rx_valid_o),
   .rx_fs48_o(rx_fs48_o), .rx_frame96_o(rx_frame96_o), .rx_ch56_o(rx_ch56_o),
   .in_src_en_o(in_src_en_o), .in_src_clk_wclk_o(in_src_clk_wclk_o), .rate_o(rate_o),
   .max_channels_o(max_channels_o), .out_timing_o(out_timing_o));
`default_nettype wire

//--- dv/madi_card_port_config_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcpc_consts.svh"

module madi_card_port_config_test;
   localparam logic [3:0]  FS = 4'hd;
   localparam logic [3:0]  FR = 4'h5;
   localparam logic [3:0]  CH = 4'h9;
   localparam logic [19:0] TB [12] = '{{13'h0000, 7'h00}, {13'h0004, 7'h40}, {13'h0008, 7'h20},
      {13'h0018, 7'h30}, {13'h0010, 7'h00}, {13'h0080, 7'h04}, {13'h0180, 7'h08}, {13'h0100, 7'h00},
      {13'h0200, 7'h02}, {13'h0400, 7'h00}, {13'h0800, 7'h00}, {13'h1000, 7'h01}};
   localparam logic [1:0]  PA [4] = '{2'h0, 2'h0, 2'h2, 2'h1};
   localparam logic [1:0]  PB [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
   logic        clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [3:0]  wb_adr = 4'h0;
   logic [31:0] wb_dat = 32'h0000_0000;
   logic [3:0]  line_en = 4'h0;
   logic        sw_on = 1'b1;
   logic [12:0] dip = 13'h0000;
   logic [31:0] rd, dat_o;
   logic [3:0]  lclk, lock, fs48, fr96, ch56;
   logic [1:0]  pa, pb, rate, otim;
   logic [6:0]  maxch;
   logic        ack, irq, wclk, rxv, rxfs, rxfr, rxch, split, isen, iswc, of96, oc56;
   int          err_total = 0;
   int          total_checks = 0;

   always #5 clk_i = ~clk_i;

   mcpc_line_model #(.FS(FS), .FR(FR), .CH(CH)) u_line (.en_i(line_en), .clk_o(lclk), .lock_o(lock),
      .fs48_o(fs48), .frame96_o(fr96), .ch56_o(ch56), .wclk_o(wclk));

   mcpc_port_config uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .irq_o(irq), .line_clk_i(lclk), .line_lock_i(lock), .line_fs48_i(fs48),
      .line_frame96_i(fr96), .line_ch56_i(ch56), .wclk_i(wclk), .host_ctrl_sw_i(sw_on), .dip_cfg_i(dip),
      .pair_a_line_o(pa), .pair_b_line_o(pb), .rx_valid_o(rxv), .rx_fs48_o(rxfs), .rx_frame96_o(rxfr),
      .rx_ch56_o(rxch), .split_en_o(split), .in_src_en_o(isen), .in_src_clk_wclk_o(iswc), .rate_o(rate),
      .max_channels_o(maxch), .out_timing_o(otim), .out_frame96_o(of96), .out_ch56_o(oc56));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
   endtask : step

   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, w, a, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_total++;
         end_sim();
      end
      rd = dat_o;
      {wb_cyc, wb_stb, wb_we} <= 3'b000;
   endtask : wb

   task automatic t_reset;
      chk(maxch, 7'h40);
      chk({otim, rxv, irq, split}, 5'h00);
      chk({pa, pb}, {2'h0, 2'h1});
      wb(1'b0, `MCPC_ADDR_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      wb(1'b0, 4'h2, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      $display("test reset done");
   endtask : t_reset

   task automatic t_ctrl;
      for (int i = 0; i < 12; i++) begin
         wb(1'b1, `MCPC_ADDR_CTRL, {19'h0, TB[i][19:7]});
         step(3);
         chk({split, isen, iswc, otim, of96, oc56}, TB[i][6:0]);
         wb(1'b0, `MCPC_ADDR_CTRL, 32'h0000_0000);
         chk(rd, {19'h0, TB[i][19:7]});
      end
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, `MCPC_ADDR_CTRL, i << 5);
         step(3);
         chk(rate, i);
         chk(maxch, 7'h40 >> i);
      end
      $display("test controls done");
   endtask : t_ctrl

   task automatic t_pairs;
      line_en <= 4'hf;
      step(10);
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, `MCPC_ADDR_CTRL, i);
         step(5);
         chk({pa, pb}, {PA[i], PB[i]});
         chk({rxv, rxfs, rxfr, rxch}, {1'b1, FS[PA[i]], FR[PA[i]], CH[PA[i]]});
         chk({of96, oc56}, {FR[PA[i]], CH[PA[i]]});
      end
      $display("test pairs done");
   endtask : t_pairs

   task automatic t_fail;
      wb(1'b1, `MCPC_ADDR_IRQ_MASK, 32'h0000_0002);
      wb(1'b1, `MCPC_ADDR_CTRL, 32'h0000_0000);
      step(5);
      wb(1'b0, `MCPC_ADDR_IRQ_STAT, 32'h0000_0000);
      step(2);
      chk(irq, 1'b0);
      line_en <= 4'he;
      step(260);
      chk({pa, irq}, {2'h2, 1'b1});
      chk({rxfs, rxfr, rxch}, {FS[2], FR[2], CH[2]});
      wb(1'b0, `MCPC_ADDR_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_5e67);
      wb(1'b0, `MCPC_ADDR_IRQ_STAT, 32'h0000_0000);
      chk(rd[1], 1'b1);
      step(2);
      chk(irq, 1'b0);
      wb(1'b0, `MCPC_ADDR_IRQ_MASK, 32'h0000_0000);
      chk(rd, 32'h0000_0002);
      line_en <= 4'h0;
      step(260);
      chk({rxv, rxfs, rxfr, rxch}, 4'h0);
      chk({of96, oc56}, 2'h0);
      $display("test failover done");
   endtask : t_fail

   task automatic t_lock;
      sw_on <= 1'b0;
      dip <= 13'h0004;
      step(6);
      chk(split, 1'b1);
      wb(1'b1, `MCPC_ADDR_CTRL, 32'h0000_0000);
      step(3);
      chk(split, 1'b1);
      wb(1'b0, `MCPC_ADDR_IRQ_STAT, 32'h0000_0000);
      chk(rd[3], 1'b1);
      wb(1'b0, `MCPC_ADDR_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0004);
      sw_on <= 1'b1;
      step(6);
      chk(split, 1'b0);
      $display("test lock done");
   endtask : t_lock

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim

   initial begin
      #50_000;
      err_total++;
      end_sim();
   end

   initial begin
      step(3);
      reset_n_i <= 1'b1;
      t_reset();
      t_ctrl();
      t_pairs();
      t_fail();
      t_lock();
      end_sim();
   end
endmodule : madi_card_port_config_test
`default_nettype wire
